// [rtl/lsx_params.svh]
// Purpose: constants for the load/store/arithmetic execution datapath
// Assumes: included by bare name from design files
// Notes: opcode field positions and encodings are local choices
`ifndef LSX_PARAMS_SVH
`define LSX_PARAMS_SVH
`define LSX_INSN_W 16
`define LSX_REG_W 24
`define LSX_ADDR_W 24
`define LSX_DATA_W 32
`define LSX_SREG_W 8
`define LSX_NREGS 8
`define LSX_OP_HI 15
`define LSX_OP_LO 11
`define LSX_MD_HI 10
`define LSX_MD_LO 9
`define LSX_RD_HI 8
`define LSX_RD_LO 6
`define LSX_RS_HI 5
`define LSX_RS_LO 3
`define LSX_IMM_HI 6
`define LSX_IMM_LO 0
`define LSX_EXT_HI 12
`define LSX_EXT_LO 0
`define LSX_CC_HI 2
`define LSX_CC_LO 1
`define LSX_SP_RST 24'h000000
`define LSX_PC_RST 24'h000000
`define LSX_FLG_N 0
`define LSX_FLG_Z 1
`define LSX_FLG_V 2
`define LSX_FLG_C 3
`endif

// [rtl/lsx_pkg.sv]
// Purpose: types for the execution datapath
// Assumes: none
// Notes: operation codes occupy insn[15:11]
package lsx_pkg;
    typedef enum logic [4:0] {
        LSX_OP_LDB_RR, LSX_OP_LDUB_RR, LSX_OP_LD_RR, LSX_OP_LD_IMM,
        LSX_OP_LDA_RR, LSX_OP_LDA_IMM, LSX_OP_LDA_SP, LSX_OP_LDA_PC,
        LSX_OP_LDA_TOSP, LSX_OP_LDA_IMMSP,
        LSX_OP_LOAD, LSX_OP_STORE, LSX_OP_SPLOAD, LSX_OP_SPSTORE,
        LSX_OP_ADD, LSX_OP_ADC, LSX_OP_SUB, LSX_OP_SBC, LSX_OP_CMP,
        LSX_OP_CMC, LSX_OP_ADDA, LSX_OP_SUBA, LSX_OP_CMPA,
        LSX_OP_ADDA_SP, LSX_OP_SUBA_SP, LSX_OP_EXT, LSX_OP_COPRO,
        LSX_OP_NOP
    } lsx_op_type;
    typedef enum logic [1:0] {
        LSX_AM_PLAIN, LSX_AM_POSTINC, LSX_AM_POSTDEC, LSX_AM_PREDEC
    } lsx_amode_type;
    typedef enum logic [1:0] {
        LSX_SZ_BYTE_S, LSX_SZ_BYTE_U, LSX_SZ_HALF, LSX_SZ_WIDE
    } lsx_size_type;
    typedef enum logic [1:0] {
        LSX_CC_ALWAYS, LSX_CC_IFC, LSX_CC_IFNC, LSX_CC_RSVD
    } lsx_cond_type;
    typedef enum {LSX_ST_RUN, LSX_ST_MEMWAIT} lsx_state_type;
endpackage

// [rtl/lsx_alu.sv]
// Purpose: add/subtract/compare unit with NZVC flags
// Assumes: operands already extended to 24 bits
// Notes: purely combinational
`timescale 1ns/1ps
`include "lsx_params.svh"
module lsx_alu #(
    parameter int WIDTH = `LSX_REG_W
) (
    // Operands
    input wire logic [WIDTH-1:0] a_i,
    input wire logic [WIDTH-1:0] b_i,
    input wire logic sub_i,
    input wire logic cin_i,
    input wire logic use_c_i,
    input wire logic wide_i,
    // Results
    output logic [WIDTH-1:0] res_o,
    output logic [3:0] flags_o
);
    initial begin
        if (WIDTH != 24) $error("lsx_alu needs WIDTH 24");
    end
    logic [WIDTH:0] sum;
    logic [WIDTH-1:0] bx;
    logic cy;
    logic [16:0] s16;
    always_comb begin
        bx = sub_i ? ~b_i : b_i;
        // Borrow is the inverted carry on subtract
        cy = use_c_i ? (sub_i ? ~cin_i : cin_i) : sub_i;
        sum = {1'b0, a_i} + {1'b0, bx} + {{WIDTH{1'b0}}, cy};
        s16 = {1'b0, a_i[15:0]} + {1'b0, bx[15:0]} + {16'h0000, cy};
        res_o = wide_i ? sum[WIDTH-1:0] : {8'h00, s16[15:0]};
        if (wide_i) begin
            flags_o[`LSX_FLG_N] = sum[WIDTH-1];
            flags_o[`LSX_FLG_Z] = (sum[WIDTH-1:0] == '0);
            flags_o[`LSX_FLG_V] = (a_i[WIDTH-1] == bx[WIDTH-1]) && (sum[WIDTH-1] != a_i[WIDTH-1]);
            flags_o[`LSX_FLG_C] = sum[WIDTH] ^ sub_i;
        end else begin
            flags_o[`LSX_FLG_N] = s16[15];
            flags_o[`LSX_FLG_Z] = (s16[15:0] == 16'h0000);
            flags_o[`LSX_FLG_V] = (a_i[15] == bx[15]) && (s16[15] != a_i[15]);
            flags_o[`LSX_FLG_C] = s16[16] ^ sub_i;
        end
    end
endmodule // lsx_alu

// [rtl/lsx_exec.sv]
// Purpose: load/store and integer arithmetic execution datapath
// Assumes: instruction memory answers in the same cycle; data bus handshakes
// Notes: the remaining instruction classes are outside this block
`timescale 1ns/1ps
`include "lsx_params.svh"
module lsx_exec #(
    parameter int NREGS = `LSX_NREGS
) (
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    input wire logic clk_en_i,
    // Instruction bus
    output logic [`LSX_ADDR_W-1:0] imem_addr_o,
    input wire logic [`LSX_INSN_W-1:0] imem_data_i,
    // Data bus
    output logic [`LSX_ADDR_W-1:0] dmem_addr_o,
    output logic [`LSX_DATA_W-1:0] dmem_wdata_o,
    output logic [3:0] dmem_be_o,
    output logic dmem_req_o,
    output logic dmem_we_o,
    input wire logic [`LSX_DATA_W-1:0] dmem_rdata_i,
    input wire logic dmem_ack_i,
    // Coprocessor port
    output logic [15:0] copro_a_o,
    output logic [15:0] copro_b_o,
    output logic [2:0] copro_fn_o,
    output logic copro_go_o,
    // Status
    output logic [`LSX_SREG_W-1:0] status_o
);
    initial begin
        if (NREGS != 8) $error("lsx_exec needs eight registers");
    end

    // Register set
    logic [`LSX_REG_W-1:0] gpr_q [NREGS];
    logic [`LSX_REG_W-1:0] sp_q;
    logic [`LSX_ADDR_W-1:0] pc_q;
    logic [`LSX_SREG_W-1:0] psr_q;
    logic [12:0] ext_q;
    logic ext_v_q;
    lsx_pkg::lsx_state_type state_q;
    logic [2:0] ld_rd_q;
    lsx_pkg::lsx_size_type ld_sz_q;

    // Decode
    logic [`LSX_INSN_W-1:0] insn;
    lsx_pkg::lsx_op_type op;
    lsx_pkg::lsx_amode_type am;
    lsx_pkg::lsx_size_type sz;
    lsx_pkg::lsx_cond_type cc;
    logic [2:0] rd;
    logic [2:0] rs;
    logic [6:0] imm7;
    logic [`LSX_REG_W-1:0] rdv;
    logic [`LSX_REG_W-1:0] rsv;
    logic [`LSX_REG_W-1:0] uimm;
    logic [`LSX_REG_W-1:0] simm;
    logic cflag;
    logic cond_ok;
    logic run;

    assign insn = imem_data_i;
    assign op = lsx_pkg::lsx_op_type'(insn[`LSX_OP_HI:`LSX_OP_LO]);
    assign am = lsx_pkg::lsx_amode_type'(insn[`LSX_MD_HI:`LSX_MD_LO]);
    assign sz = lsx_pkg::lsx_size_type'(insn[`LSX_MD_HI:`LSX_MD_LO]);
    assign cc = lsx_pkg::lsx_cond_type'(insn[`LSX_CC_HI:`LSX_CC_LO]);
    assign rd = insn[`LSX_RD_HI:`LSX_RD_LO];
    assign rs = insn[`LSX_RS_HI:`LSX_RS_LO];
    assign imm7 = insn[`LSX_IMM_HI:`LSX_IMM_LO];
    assign rdv = gpr_q[rd];
    assign rsv = gpr_q[rs];
    assign cflag = psr_q[`LSX_FLG_C];
    assign run = clk_en_i && (state_q == lsx_pkg::LSX_ST_RUN);

    // Extended immediate: prefix bits above the 7-bit field
    function automatic logic [23:0] ext_imm(input logic [6:0] i, input logic sgn,
                                             input logic v, input logic [12:0] e);
        if (v) ext_imm = {4'h0, e, i};
        else if (sgn) ext_imm = {{17{i[6]}}, i};
        else ext_imm = {17'h00000, i};
    endfunction

    function automatic logic [23:0] size_step(input lsx_pkg::lsx_size_type s);
        case (s)
            lsx_pkg::LSX_SZ_HALF: size_step = 24'h000002;
            lsx_pkg::LSX_SZ_WIDE: size_step = 24'h000004;
            default: size_step = 24'h000001;
        endcase
    endfunction

    function automatic logic [23:0] load_ext(input lsx_pkg::lsx_size_type s,
                                              input logic [31:0] d);
        case (s)
            lsx_pkg::LSX_SZ_BYTE_S: load_ext = {{16{d[7]}}, d[7:0]};
            lsx_pkg::LSX_SZ_BYTE_U: load_ext = {16'h0000, d[7:0]};
            lsx_pkg::LSX_SZ_HALF: load_ext = {8'h00, d[15:0]};
            default: load_ext = d[23:0];
        endcase
    endfunction

    assign uimm = ext_imm(imm7, 1'b0, ext_v_q, ext_q);
    assign simm = ext_imm(imm7, 1'b1, ext_v_q, ext_q);

    always_comb begin
        case (cc)
            lsx_pkg::LSX_CC_IFC: cond_ok = cflag;
            lsx_pkg::LSX_CC_IFNC: cond_ok = ~cflag;
            default: cond_ok = 1'b1;
        endcase
    end

    // Memory op decode: the size sits in the mode field, the pointer mode in insn[1:0]
    lsx_pkg::lsx_amode_type pm;
    logic is_mem;
    logic is_sp_mem;
    logic sp_off;
    logic [`LSX_REG_W-1:0] base;
    logic [`LSX_REG_W-1:0] step;
    logic [`LSX_REG_W-1:0] eff;
    logic [`LSX_REG_W-1:0] newbase;
    assign pm = lsx_pkg::lsx_amode_type'(insn[1:0]);
    assign is_mem = (op == lsx_pkg::LSX_OP_LOAD) || (op == lsx_pkg::LSX_OP_STORE);
    assign is_sp_mem = (op == lsx_pkg::LSX_OP_SPLOAD) || (op == lsx_pkg::LSX_OP_SPSTORE);
    assign sp_off = is_sp_mem && insn[2];
    assign step = size_step(sz);

    always_comb begin
        base = is_sp_mem ? sp_q : gpr_q[insn[5:3]];
        newbase = base;
        eff = base;
        if (sp_off) begin
            eff = sp_q + {17'h00000, imm7};
        end else begin
            case (pm)
                lsx_pkg::LSX_AM_POSTINC: newbase = base + step;
                lsx_pkg::LSX_AM_POSTDEC: newbase = base - step;
                lsx_pkg::LSX_AM_PREDEC: begin
                    newbase = base - step;
                    eff = base - step;
                end
                default: newbase = base;
            endcase
        end
    end

    // Arithmetic operand selection
    logic [`LSX_REG_W-1:0] alu_a;
    logic [`LSX_REG_W-1:0] alu_b;
    logic [`LSX_REG_W-1:0] alu_res;
    logic [3:0] alu_flags;
    logic alu_sub;
    logic alu_usec;
    logic alu_wide;
    logic use_imm;
    assign use_imm = insn[`LSX_MD_HI];

    always_comb begin
        alu_a = rdv;
        alu_b = use_imm ? uimm : rsv;
        alu_sub = 1'b0;
        alu_usec = 1'b0;
        alu_wide = 1'b0;
        case (op)
            lsx_pkg::LSX_OP_ADC: alu_usec = 1'b1;
            lsx_pkg::LSX_OP_SUB: alu_sub = 1'b1;
            lsx_pkg::LSX_OP_SBC: begin
                alu_sub = 1'b1;
                alu_usec = 1'b1;
            end
            lsx_pkg::LSX_OP_CMP: begin
                alu_sub = 1'b1;
                alu_b = use_imm ? simm : rsv;
            end
            lsx_pkg::LSX_OP_CMC: begin
                alu_sub = 1'b1;
                alu_usec = 1'b1;
                alu_b = rsv;
            end
            lsx_pkg::LSX_OP_ADDA: alu_wide = 1'b1;
            lsx_pkg::LSX_OP_SUBA: begin
                alu_wide = 1'b1;
                alu_sub = 1'b1;
            end
            lsx_pkg::LSX_OP_CMPA: begin
                alu_wide = 1'b1;
                alu_sub = 1'b1;
            end
            lsx_pkg::LSX_OP_ADDA_SP: begin
                alu_wide = 1'b1;
                alu_a = sp_q;
            end
            lsx_pkg::LSX_OP_SUBA_SP: begin
                alu_wide = 1'b1;
                alu_sub = 1'b1;
                alu_a = sp_q;
            end
            default: alu_sub = 1'b0;
        endcase
    end

    lsx_alu #(.WIDTH(`LSX_REG_W)) u_alu (
        .a_i(alu_a),
        .b_i(alu_b),
        .sub_i(alu_sub),
        .cin_i(cflag),
        .use_c_i(alu_usec),
        .wide_i(alu_wide),
        .res_o(alu_res),
        .flags_o(alu_flags)
    );

    logic is_arith;
    logic writes_rd;
    assign is_arith = (op >= lsx_pkg::LSX_OP_ADD) && (op <= lsx_pkg::LSX_OP_SUBA_SP);
    assign writes_rd = is_arith && (op != lsx_pkg::LSX_OP_CMP) && (op != lsx_pkg::LSX_OP_CMC)
        && (op != lsx_pkg::LSX_OP_CMPA) && (op != lsx_pkg::LSX_OP_ADDA_SP)
        && (op != lsx_pkg::LSX_OP_SUBA_SP);

    // Sequencer: memory loads and stores wait for the data bus, all else is single cycle
    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            state_q <= lsx_pkg::LSX_ST_RUN;
            ld_rd_q <= 3'h0;
            ld_sz_q <= lsx_pkg::LSX_SZ_BYTE_S;
        end else if (clk_en_i) begin
            case (state_q)
                lsx_pkg::LSX_ST_RUN: begin
                    if (is_mem || is_sp_mem) begin
                        state_q <= lsx_pkg::LSX_ST_MEMWAIT;
                        ld_rd_q <= rd;
                        ld_sz_q <= is_sp_mem ? lsx_pkg::LSX_SZ_WIDE : sz;
                    end
                end
                lsx_pkg::LSX_ST_MEMWAIT: begin
                    if (dmem_ack_i) state_q <= lsx_pkg::LSX_ST_RUN;
                end
                default: state_q <= lsx_pkg::LSX_ST_RUN;
            endcase
        end
    end

    // Program counter, one fetch per cycle in the run state
    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            pc_q <= `LSX_PC_RST;
        end else if (run) begin
            pc_q <= pc_q + 24'h000002;
        end
    end

    // Extension prefix holds until the next instruction consumes it
    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            ext_q <= 13'h0000;
            ext_v_q <= 1'b0;
        end else if (run) begin
            ext_v_q <= (op == lsx_pkg::LSX_OP_EXT);
            if (op == lsx_pkg::LSX_OP_EXT) ext_q <= insn[`LSX_EXT_HI:`LSX_EXT_LO];
        end
    end

    // Flags
    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            psr_q <= 8'h00;
        end else if (run && is_arith && cond_ok) begin
            psr_q[3:0] <= alu_flags;
        end
    end

    // Stack pointer
    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            sp_q <= `LSX_SP_RST;
        end else if (run) begin
            if (op == lsx_pkg::LSX_OP_LDA_TOSP) sp_q <= rsv;
            else if (op == lsx_pkg::LSX_OP_LDA_IMMSP) sp_q <= uimm;
            else if ((op == lsx_pkg::LSX_OP_ADDA_SP || op == lsx_pkg::LSX_OP_SUBA_SP) && cond_ok)
                sp_q <= alu_res;
            else if (is_sp_mem && !sp_off) sp_q <= newbase;
        end
    end

    // General registers
    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            for (int i = 0; i < NREGS; i++) gpr_q[i] <= 24'h000000;
        end else if (clk_en_i) begin
            if (state_q == lsx_pkg::LSX_ST_MEMWAIT) begin
                if (dmem_ack_i && !dmem_we_o) gpr_q[ld_rd_q] <= load_ext(ld_sz_q, dmem_rdata_i);
            end else begin
                case (op)
                    lsx_pkg::LSX_OP_LDB_RR: gpr_q[rd] <= load_ext(lsx_pkg::LSX_SZ_BYTE_S, {8'h00, rsv});
                    lsx_pkg::LSX_OP_LDUB_RR: gpr_q[rd] <= load_ext(lsx_pkg::LSX_SZ_BYTE_U, {8'h00, rsv});
                    lsx_pkg::LSX_OP_LD_RR: gpr_q[rd] <= {8'h00, rsv[15:0]};
                    lsx_pkg::LSX_OP_LD_IMM: gpr_q[rd] <= simm;
                    lsx_pkg::LSX_OP_LDA_RR: gpr_q[rd] <= rsv;
                    lsx_pkg::LSX_OP_LDA_IMM: gpr_q[rd] <= uimm;
                    lsx_pkg::LSX_OP_LDA_SP: gpr_q[rd] <= sp_q;
                    lsx_pkg::LSX_OP_LDA_PC: gpr_q[rd] <= pc_q;
                    lsx_pkg::LSX_OP_LOAD, lsx_pkg::LSX_OP_STORE:
                        if (!sp_off) gpr_q[insn[5:3]] <= newbase;
                    default: if (writes_rd && cond_ok) gpr_q[rd] <= alu_res;
                endcase
            end
        end
    end

    // Data bus and coprocessor outputs
    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            dmem_req_o <= 1'b0;
            dmem_we_o <= 1'b0;
            dmem_addr_o <= 24'h000000;
            dmem_wdata_o <= 32'h00000000;
            dmem_be_o <= 4'h0;
            copro_a_o <= 16'h0000;
            copro_b_o <= 16'h0000;
            copro_fn_o <= 3'h0;
            copro_go_o <= 1'b0;
        end else if (clk_en_i) begin
            copro_go_o <= run && (op == lsx_pkg::LSX_OP_COPRO);
            if (run && op == lsx_pkg::LSX_OP_COPRO) begin
                copro_a_o <= rdv[15:0];
                copro_b_o <= rsv[15:0];
                copro_fn_o <= insn[2:0];
            end
            if (run && (is_mem || is_sp_mem)) begin
                dmem_req_o <= 1'b1;
                dmem_addr_o <= eff;
                dmem_we_o <= (op == lsx_pkg::LSX_OP_STORE) || (op == lsx_pkg::LSX_OP_SPSTORE);
                dmem_wdata_o <= {8'h00, gpr_q[rd]};
                case (is_sp_mem ? lsx_pkg::LSX_SZ_WIDE : sz)
                    lsx_pkg::LSX_SZ_HALF: dmem_be_o <= 4'h3;
                    lsx_pkg::LSX_SZ_WIDE: dmem_be_o <= 4'hf;
                    default: dmem_be_o <= 4'h1;
                endcase
            end else if (dmem_ack_i) begin
                dmem_req_o <= 1'b0;
            end
        end
    end

    assign imem_addr_o = pc_q;
    assign status_o = psr_q;

    chk_wide_store_top: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        dmem_req_o && dmem_we_o |-> dmem_wdata_o[31:24] == 8'h00)
        else $error("wide store top byte not zero");
    chk_pc_step_one: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        run |=> pc_q == $past(pc_q) + 24'h000002)
        else $error("pc did not advance in one cycle");
    chk_cond_flags: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        run && is_arith && !cond_ok |=> psr_q == $past(psr_q))
        else $error("skipped conditional changed flags");
    chk_sp_load_reg: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        run && op == lsx_pkg::LSX_OP_LDA_TOSP |=> sp_q == $past(rsv))
        else $error("sp not loaded from register");
    chk_req_ack: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        state_q == lsx_pkg::LSX_ST_MEMWAIT |-> dmem_req_o)
        else $error("waiting without request");
    chk_ext_clear: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        run && op != lsx_pkg::LSX_OP_EXT |=> !ext_v_q)
        else $error("extension outlived next instruction");
    chk_copro_pulse: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        clk_en_i && copro_go_o && !(run && op == lsx_pkg::LSX_OP_COPRO) |=> !copro_go_o)
        else $error("coprocessor start not a pulse");
    chk_wide_enable: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        run && is_sp_mem && clk_en_i |=> dmem_be_o == 4'hf)
        else $error("stack access not wide");
endmodule // lsx_exec

// [testbench/lsx_mem_model.sv]
// Purpose: instruction and data memory facing the execution datapath
// Assumes: fetch answers in the same cycle; data ack after 0..3 cycles
// Notes: idle read data inverts each cycle so a stale word never passes
`timescale 1ns/1ps
module lsx_mem_model (
    // Clock
    input wire logic core_clk_i,
    // Instruction bus
    input wire logic [23:0] imem_addr_i,
    output logic [15:0] imem_data_o,
    // Data bus
    input wire logic [23:0] dmem_addr_i,
    input wire logic [31:0] dmem_wdata_i,
    input wire logic [3:0] dmem_be_i,
    input wire logic dmem_req_i,
    input wire logic dmem_we_i,
    output logic [31:0] dmem_rdata_o,
    output logic dmem_ack_o
);
    logic [15:0] imem [512];
    logic [31:0] dmem [256];
    logic [1:0] cnt_q = 2'h0;
    logic [1:0] dly_q = 2'h0;
    initial dmem_ack_o = 1'b0;
    initial dmem_rdata_o = 32'h0;
    assign imem_data_o = imem[imem_addr_i[9:1]];
    always @(posedge core_clk_i) begin
        dmem_ack_o <= 1'b0;
        if (dmem_req_i && !dmem_ack_o && cnt_q == dly_q) begin
            // Stall varies 0..3 cycles per access
            dmem_ack_o <= 1'b1;
            cnt_q <= 2'h0;
            dly_q <= dly_q + 2'h1;
            dmem_rdata_o <= dmem[dmem_addr_i[9:2]];
            for (int i = 0; i < 4; i++) begin
                if (dmem_we_i && dmem_be_i[i])
                    dmem[dmem_addr_i[9:2]][i*8 +: 8] <= dmem_wdata_i[i*8 +: 8];
            end
        end else begin
            if (dmem_req_i && !dmem_ack_o)
                cnt_q <= cnt_q + 2'h1;
            dmem_rdata_o <= ~dmem_rdata_o;
        end
    end
endmodule // lsx_mem_model

// [testbench/cpu_load_store_arith_exec_tb.sv]
// Purpose: self-checking bench for the execution datapath
// Assumes: program placed in model memory while reset is held
// Notes: stores are the window on registers; flags seen at each store
`timescale 1ns/1ps
module cpu_load_store_arith_exec_tb;
    logic core_clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic clk_en_i = 1'b1;
    logic [23:0] imem_addr, dmem_addr;
    logic [15:0] imem_data;
    logic [31:0] dmem_wdata, dmem_rdata;
    logic [3:0] dmem_be;
    logic dmem_req, dmem_we, dmem_ack;
    logic [7:0] status;
    logic [23:0] rf [8];
    logic [3:0] mf = 4'h0;
    logic [23:0] mptr = 24'h40;
    logic [15:0] lfsr_q = 16'h98dd;
    logic [23:0] pc_seen;
    logic [23:0] ea [$], ga [$];
    logic [31:0] ed [$], em [$], gd [$];
    logic [3:0] eb [$], ef [$], gb [$], gf [$];
    int pc_n = 0;
    int n_errors = 0;
    int n_compared = 0;
    always #50 core_clk_i = ~core_clk_i;
    lsx_exec dut (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .clk_en_i(clk_en_i),
        .imem_addr_o(imem_addr), .imem_data_i(imem_data), .dmem_addr_o(dmem_addr),
        .dmem_wdata_o(dmem_wdata), .dmem_be_o(dmem_be), .dmem_req_o(dmem_req),
        .dmem_we_o(dmem_we), .dmem_rdata_i(dmem_rdata), .dmem_ack_i(dmem_ack),
        .copro_a_o(), .copro_b_o(), .copro_fn_o(), .copro_go_o(), .status_o(status));
    lsx_mem_model mdl (.core_clk_i(core_clk_i), .imem_addr_i(imem_addr),
        .imem_data_o(imem_data), .dmem_addr_i(dmem_addr), .dmem_wdata_i(dmem_wdata),
        .dmem_be_i(dmem_be), .dmem_req_i(dmem_req), .dmem_we_i(dmem_we),
        .dmem_rdata_o(dmem_rdata), .dmem_ack_o(dmem_ack));
    always @(posedge core_clk_i) begin
        if (rst_n_i && dmem_req && dmem_ack && dmem_we) begin
            ga.push_back(dmem_addr);
            gd.push_back(dmem_wdata);
            gb.push_back(dmem_be);
            gf.push_back(status[3:0]);
        end
    end
    function automatic logic [15:0] lfsr(input logic [15:0] x);
        return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
    endfunction
    function automatic logic [15:0] ins(input lsx_pkg::lsx_op_type op, input logic [1:0] md,
        input logic [2:0] rd, input logic [2:0] rs, input logic [2:0] lo);
        return {op, md, rd, rs, lo};
    endfunction
    task automatic put(input logic [15:0] w);
        mdl.imem[pc_n] = w;
        pc_n++;
    endtask
    // Prefix plus 7-bit immediate; rd bit 0 shares insn bit 6
    task automatic ld_const(input logic [2:0] rd, input logic [10:0] x, input logic [5:0] i);
        put({lsx_pkg::LSX_OP_EXT, x});
        put({lsx_pkg::LSX_OP_LDA_IMM, 2'h0, rd, i});
        rf[rd] = {4'h0, 2'b01, x, rd[0], i};
    endtask
    task automatic store(input logic [2:0] rd, input lsx_pkg::lsx_size_type sz,
        input lsx_pkg::lsx_amode_type am);
        logic [23:0] st;
        logic wd;
        wd = (sz == lsx_pkg::LSX_SZ_WIDE);
        st = wd ? 24'h4 : 24'h2;
        if (am == lsx_pkg::LSX_AM_PREDEC)
            mptr = mptr - st;
        put(ins(lsx_pkg::LSX_OP_STORE, sz, rd, 3'h1, {1'b0, am}));
        ea.push_back(mptr);
        ed.push_back(wd ? {8'h0, rf[rd]} : {16'h0, rf[rd][15:0]});
        em.push_back(wd ? 32'hffffffff : 32'h0000ffff);
        eb.push_back(wd ? 4'hf : 4'h3);
        ef.push_back(mf);
        if (am == lsx_pkg::LSX_AM_POSTINC)
            mptr = mptr + st;
        if (am == lsx_pkg::LSX_AM_POSTDEC)
            mptr = mptr - st;
    endtask
    // r2 = r2 op r3; opcodes 14..22 run from add up to address-width compare
    task automatic arith(input int k, input logic [1:0] cc);
        logic [24:0] a, b, s;
        logic w24, sb, cy, hi;
        int w;
        w24 = (k >= 20);
        w = w24 ? 24 : 16;
        sb = k inside {16, 17, 18, 19, 21, 22};
        cy = (k inside {15, 17, 19}) && mf[3];
        a = w24 ? {1'b0, rf[2]} : {9'h0, rf[2][15:0]};
        b = w24 ? {1'b0, rf[3]} : {9'h0, rf[3][15:0]};
        s = sb ? a - b - 25'(cy) : a + b + 25'(cy);
        hi = s[w-1];
        put(ins(lsx_pkg::lsx_op_type'(k), 2'h0, 3'h2, 3'h3, {cc, 1'b0}));
        if (cc == 2'h0 || (cc == 2'h1) == mf[3]) begin
            mf[3] = s[w];
            mf[2] = (sb ? a[w-1] != b[w-1] : a[w-1] == b[w-1]) && hi != a[w-1];
            mf[1] = w24 ? s[23:0] == 24'h0 : s[15:0] == 16'h0;
            mf[0] = hi;
            if (!(k inside {18, 19, 22}))
                rf[2] = w24 ? s[23:0] : {8'h0, s[15:0]};
        end
    endtask
    task automatic chk32(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (e !== g) begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic chk4(input string nm, input logic [3:0] e, input logic [3:0] g);
        n_compared++;
        if (e !== g) begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic end_of_test();
        $display("compared %0d mismatches %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    initial begin
        #(100 * 20000);
        n_errors++;
        end_of_test();
    end
    initial begin
        #1;
        put({lsx_pkg::LSX_OP_LDA_IMM, 2'h0, 3'h1, 6'h0});
        mdl.dmem[16] = 32'ha5c3b2e1;
        put(ins(lsx_pkg::LSX_OP_LOAD, lsx_pkg::LSX_SZ_WIDE, 3'h4, 3'h1, 3'h0));
        rf[4] = 24'hc3b2e1;
        store(3'h4, lsx_pkg::LSX_SZ_WIDE, lsx_pkg::LSX_AM_PLAIN);
        ld_const(3'h2, 11'h5a3, 6'h15);
        store(3'h2, lsx_pkg::LSX_SZ_WIDE, lsx_pkg::LSX_AM_POSTINC);
        store(3'h2, lsx_pkg::LSX_SZ_WIDE, lsx_pkg::LSX_AM_PREDEC);
        store(3'h2, lsx_pkg::LSX_SZ_WIDE, lsx_pkg::LSX_AM_POSTDEC);
        store(3'h2, lsx_pkg::LSX_SZ_WIDE, lsx_pkg::LSX_AM_PLAIN);
        put({lsx_pkg::LSX_OP_LD_IMM, 2'h0, 3'h5, 6'h3e});
        put(ins(lsx_pkg::LSX_OP_LDB_RR, 2'h0, 3'h6, 3'h5, 3'h0));
        put(ins(lsx_pkg::LSX_OP_LDUB_RR, 2'h0, 3'h7, 3'h5, 3'h0));
        rf[5] = 24'hfffffe;
        rf[6] = 24'hfffffe;
        rf[7] = 24'h0000fe;
        store(3'h6, lsx_pkg::LSX_SZ_WIDE, lsx_pkg::LSX_AM_PLAIN);
        store(3'h7, lsx_pkg::LSX_SZ_WIDE, lsx_pkg::LSX_AM_PLAIN);
        store(3'h5, lsx_pkg::LSX_SZ_HALF, lsx_pkg::LSX_AM_PLAIN);
        // First nine passes cover opcodes 14..22 once each, unconditionally
        for (int i = 0; i < 30; i++) begin
            lfsr_q = lfsr(lfsr_q);
            ld_const(3'h2, lfsr_q[10:0], lfsr_q[15:10]);
            lfsr_q = lfsr(lfsr_q);
            ld_const(3'h3, lfsr_q[10:0], lfsr_q[15:10]);
            lfsr_q = lfsr(lfsr_q);
            arith(i < 9 ? 14 + i : 14 + lfsr_q % 9, i < 9 ? 2'h0 : 2'(lfsr_q[5:4] % 3));
            store(3'h2, lsx_pkg::LSX_SZ_WIDE, lsx_pkg::LSX_AM_PLAIN);
        end
        repeat (4) @(posedge core_clk_i);
        rst_n_i <= 1'b1;
        for (int t = 0; t < 4000 && ga.size() < ea.size(); t++)
            @(posedge core_clk_i);
        $display("test run done, stores seen %0d", ga.size());
        chk32("store count", 32'(ea.size()), 32'(ga.size()));
        for (int j = 0; j < ea.size() && j < ga.size(); j++) begin
            chk32("address", {8'h0, ea[j]}, {8'h0, ga[j]});
            chk32("data", ed[j], gd[j] & em[j]);
            chk4("lanes", eb[j], gb[j]);
            chk4("flags", ef[j], gf[j]);
        end
        $display("test compare done");
        // Freeze: clock enable low must hold the fetch address
        @(posedge core_clk_i);
        clk_en_i <= 1'b0;
        @(posedge core_clk_i);
        #1 pc_seen = imem_addr;
        repeat (3) @(posedge core_clk_i);
        #1 chk32("frozen pc", {8'h0, pc_seen}, {8'h0, imem_addr});
        @(posedge core_clk_i);
        clk_en_i <= 1'b1;
        @(posedge core_clk_i);
        #1 chk32("resumed pc", {8'h0, pc_seen + 24'h000002}, {8'h0, imem_addr});
        $display("test freeze done");
        end_of_test();
    end
endmodule // cpu_load_store_arith_exec_tb
